// ### rtl/wss_sequencer.sv
//
// Contract
// - delay flag set: idle 10 ms per count
// - delay flag clear: field is waveform identifier
// - identifier bits 6..0 index the library
// - go bit starts playback at first slot
// - after a slot, play the following slot
// - end after the eighth slot (code ends after slot NUM_SLOTS, eight by default)
// - zero identifier stops sequencer, plays nothing
//
`timescale 1ns/1ps
`include "wss_consts.svh"
module wss_sequencer #(
  parameter int NUM_SLOTS = 8,
  parameter int DELAY_UNIT_CYCLES = `WSS_DELAY_UNIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire wss_pkg::wss_bus_req_t busReq,
  output logic [7:0] busRdata,
  // waveform library
  output wss_pkg::wss_wave_req_t waveReq,
  input wire logic waveDone,
  // status
  output logic seqBusy,
  output logic engineIdle
);
  import wss_pkg::*;

  // ----------------------------------------------------------------
  // parameters and checks
  // ----------------------------------------------------------------
  localparam int PTR_W = 3;
  localparam int MAX_SLOTS = 8;
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(NUM_SLOTS - 1);
  localparam logic [7:0] LAST_ADDR =
    `WSS_ADDR_SLOT_FIRST + 8'(NUM_SLOTS - 1);
  localparam logic [7:0] CTRL_RESET = `WSS_CTRL_RESET;

  if (int'(`WSS_ADDR_SLOT_FIRST) + MAX_SLOTS - 1 !=
      int'(`WSS_ADDR_SLOT_LAST)) begin : g_bad_map
    $error("wss_sequencer: slot map must span eight slots");
  end

  if (NUM_SLOTS < 1 || NUM_SLOTS > MAX_SLOTS) begin : g_bad_slots
    $error("wss_sequencer: NUM_SLOTS must be 1 to 8");
  end
  if (DELAY_UNIT_CYCLES < 1) begin : g_bad_delay
    $error("wss_sequencer: DELAY_UNIT_CYCLES must be positive");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic slotHit(input logic [7:0] a);
    return (a >= `WSS_ADDR_SLOT_FIRST) && (a <= LAST_ADDR);
  endfunction

  function automatic logic [PTR_W-1:0] slotOf(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `WSS_ADDR_SLOT_FIRST;
    return rel[PTR_W-1:0];
  endfunction

  function automatic logic ctrlHit(input logic [7:0] a);
    return a == `WSS_ADDR_CTRL;
  endfunction

  function automatic logic statHit(input logic [7:0] a);
    return a == `WSS_ADDR_STATUS;
  endfunction

  function automatic logic stopSlot(input wss_slot_t s);
    return !s.delayFlag && (s.index == 7'h00);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wss_slot_t slotReg [NUM_SLOTS];
  wss_slot_t slotNext [NUM_SLOTS];
  wss_slot_t curSlot;

  logic goReg;
  logic goNext;
  logic ctrlWrite;
  logic endSeq;

  wss_state_t stateReg;
  wss_state_t stateNext;
  logic [PTR_W-1:0] ptrReg;
  logic [PTR_W-1:0] ptrNext;
  logic [6:0] idxReg;
  logic [6:0] idxNext;
  logic startReg;
  logic startNext;

  logic timerStart;
  logic timerAbort;
  logic timerDone;
  logic timerBusy;

  logic [7:0] rdataReg;
  logic [7:0] rdataNext;
  logic [7:0] statusWord;

  // ----------------------------------------------------------------
  // slot registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
      always_comb begin
        slotNext[gi] = slotReg[gi];
        if (busReq.wr && slotHit(busReq.addr) &&
            slotOf(busReq.addr) == PTR_W'(gi)) begin
          slotNext[gi] = busReq.wdata;
        end
      end

      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          slotReg[gi] <= (gi == 0) ? `WSS_SLOT_FIRST_RESET
                                   : `WSS_SLOT_RESET;
        end else begin
          slotReg[gi] <= slotNext[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // go bit
  // ----------------------------------------------------------------
  assign ctrlWrite = busReq.wr && ctrlHit(busReq.addr);

  always_comb begin
    goNext = goReg;
    if (endSeq) begin
      goNext = 1'b0;
    end
    // software write wins over the end-of-sequence clear
    if (ctrlWrite) begin
      goNext = busReq.wdata[`WSS_CTRL_GO_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      goReg <= CTRL_RESET[`WSS_CTRL_GO_BIT];
    end else begin
      goReg <= goNext;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign curSlot = slotReg[ptrReg];

  always_comb begin
    stateNext = stateReg;
    ptrNext = ptrReg;
    idxNext = idxReg;
    startNext = 1'b0;
    timerStart = 1'b0;
    timerAbort = 1'b0;
    endSeq = 1'b0;
    case (stateReg)
      WSS_IDLE: begin
        if (goReg) begin
          ptrNext = '0;
          stateNext = WSS_FETCH;
        end
      end
      WSS_FETCH: begin
        if (stopSlot(curSlot)) begin
          stateNext = WSS_IDLE;
          endSeq = 1'b1;
        end else if (curSlot.delayFlag) begin
          timerStart = 1'b1;
          stateNext = WSS_WAIT;
        end else begin
          idxNext = curSlot.index;
          startNext = 1'b1;
          stateNext = WSS_PLAY;
        end
      end
      WSS_PLAY: begin
        if (waveDone) begin
          if (ptrReg == LAST_PTR) begin
            stateNext = WSS_IDLE;
            endSeq = 1'b1;
          end else begin
            ptrNext = ptrReg + PTR_W'(1);
            stateNext = WSS_FETCH;
          end
        end
      end
      WSS_WAIT: begin
        if (timerDone) begin
          if (ptrReg == LAST_PTR) begin
            stateNext = WSS_IDLE;
            endSeq = 1'b1;
          end else begin
            ptrNext = ptrReg + PTR_W'(1);
            stateNext = WSS_FETCH;
          end
        end
      end
      default: begin
        stateNext = WSS_IDLE;
      end
    endcase
    // clearing the go bit aborts a running sequence
    if (!goReg && stateReg != WSS_IDLE) begin
      stateNext = WSS_IDLE;
      startNext = 1'b0;
      timerStart = 1'b0;
      timerAbort = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= WSS_IDLE;
      ptrReg <= '0;
      idxReg <= '0;
      startReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      ptrReg <= ptrNext;
      idxReg <= idxNext;
      startReg <= startNext;
    end
  end

  // ----------------------------------------------------------------
  // delay timer
  // ----------------------------------------------------------------
  wss_delay_timer #(
    .UNIT_CYCLES(DELAY_UNIT_CYCLES),
    .UNITS_W(7)
  ) u_delay (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(timerStart),
    .abort(timerAbort),
    .units(curSlot.index),
    .busy(timerBusy),
    .done(timerDone)
  );

  // ----------------------------------------------------------------
  // waveform request
  // ----------------------------------------------------------------
  always_comb begin
    waveReq.start = startReg;
    waveReq.active = (stateReg == WSS_PLAY);
    waveReq.index = idxReg;
  end

  assign seqBusy = (stateReg != WSS_IDLE);
  assign engineIdle = (stateReg == WSS_WAIT) && timerBusy;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    statusWord = 8'h00;
    statusWord[`WSS_STAT_BUSY_BIT] = seqBusy;
    statusWord[`WSS_STAT_WAIT_BIT] = (stateReg == WSS_WAIT);
    statusWord[`WSS_STAT_PLAY_BIT] = (stateReg == WSS_PLAY);
    statusWord[`WSS_STAT_PTR_LSB +: PTR_W] = ptrReg;
  end

  always_comb begin
    rdataNext = 8'h00;
    if (busReq.rd) begin
      if (slotHit(busReq.addr)) begin
        rdataNext = slotReg[slotOf(busReq.addr)];
      end else if (ctrlHit(busReq.addr)) begin
        rdataNext[`WSS_CTRL_GO_BIT] = goReg;
      end else if (statHit(busReq.addr)) begin
        rdataNext = statusWord;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdataReg <= 8'h00;
    end else begin
      rdataReg <= rdataNext;
    end
  end

  assign busRdata = rdataReg;

endmodule

// ### rtl/wss_consts.svh
`ifndef WSS_CONSTS_SVH
`define WSS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WSS_ADDR_CTRL 8'h0c
`define WSS_ADDR_SLOT_FIRST 8'h0f
`define WSS_ADDR_SLOT_TWO 8'h10
`define WSS_ADDR_SLOT_THREE 8'h11
`define WSS_ADDR_SLOT_LAST 8'h16
`define WSS_ADDR_STATUS 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WSS_CTRL_GO_BIT 0
`define WSS_SLOT_FLAG_BIT 7
`define WSS_SLOT_INDEX_MSB 6
`define WSS_STAT_BUSY_BIT 0
`define WSS_STAT_WAIT_BIT 1
`define WSS_STAT_PLAY_BIT 2
`define WSS_STAT_PTR_LSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WSS_SLOT_FIRST_RESET 8'h01
`define WSS_SLOT_RESET 8'h00
`define WSS_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WSS_DELAY_UNIT_MS 10
`define WSS_CLK_FREQ_KHZ 50000
`define WSS_DELAY_UNIT_CYCLES (`WSS_DELAY_UNIT_MS * `WSS_CLK_FREQ_KHZ)

`endif

// ### rtl/wss_pkg.sv
package wss_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic delayFlag;
    logic [6:0] index;
  } wss_slot_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wss_bus_req_t;

  typedef struct packed {
    logic start;
    logic active;
    logic [6:0] index;
  } wss_wave_req_t;

  typedef enum logic [1:0] {
    WSS_IDLE  = 2'b00,
    WSS_FETCH = 2'b01,
    WSS_PLAY  = 2'b11,
    WSS_WAIT  = 2'b10
  } wss_state_t;

endpackage

// ### rtl/wss_delay_timer.sv
`timescale 1ns/1ps
module wss_delay_timer #(
  parameter int UNIT_CYCLES = 500000,
  parameter int UNITS_W = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [UNITS_W-1:0] units,
  // result
  output logic busy,
  output logic done
);

  localparam int TICK_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(UNIT_CYCLES - 1);

  if (UNIT_CYCLES < 1 || UNITS_W < 1) begin : g_bad_param
    $error("wss_delay_timer: unsupported parameter value");
  end

  logic runReg;
  logic runNext;
  logic [TICK_W-1:0] tickReg;
  logic [TICK_W-1:0] tickNext;
  logic [UNITS_W-1:0] unitReg;
  logic [UNITS_W-1:0] unitNext;

  // ----------------------------------------------------------------
  // unit countdown
  // ----------------------------------------------------------------
  always_comb begin
    runNext = runReg;
    tickNext = tickReg;
    unitNext = unitReg;
    done = 1'b0;
    if (abort) begin
      runNext = 1'b0;
    end else if (start) begin
      runNext = 1'b1;
      tickNext = '0;
      unitNext = units;
    end else if (runReg) begin
      if (unitReg == '0) begin
        runNext = 1'b0;
        done = 1'b1;
      end else if (tickReg == TICK_LAST) begin
        tickNext = '0;
        unitNext = unitReg - UNITS_W'(1);
      end else begin
        tickNext = tickReg + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      runReg <= 1'b0;
      tickReg <= '0;
      unitReg <= '0;
    end else begin
      runReg <= runNext;
      tickReg <= tickNext;
      unitReg <= unitNext;
    end
  end

  assign busy = runReg;

endmodule

// ### verif/wss_seq_checker.sv
`timescale 1ns/1ps
module wss_seq_checker #(
  parameter int NUM_SLOTS = 8,
  parameter int DELAY_UNIT_CYCLES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire wss_pkg::wss_bus_req_t busReq,
  input wire logic [7:0] busRdata,
  // waveform library
  input wire wss_pkg::wss_wave_req_t waveReq,
  input wire logic waveDone,
  // status
  input wire logic seqBusy,
  input wire logic engineIdle
);
  import wss_pkg::*;
  // ----------------------------------------------------------------
  // idle run length
  // ----------------------------------------------------------------
  logic [31:0] idleLen_reg;
  logic [31:0] idleLen_next;
  always_comb begin
    idleLen_next = engineIdle ? idleLen_reg + 32'h00000001 : 32'h00000000;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idleLen_reg <= 32'h00000000;
    end else begin
      idleLen_reg <= idleLen_next;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wave_launch;
    waveReq.start ##0 seqBusy;
  endsequence
  sequence s_wave_end;
    waveReq.active && !waveReq.start && waveDone;
  endsequence
  a_start_needs_busy: assert property (
    waveReq.start |-> seqBusy) else $error("start while sequencer idle");
  a_start_one_pulse: assert property (
    s_wave_launch |=> !waveReq.start) else $error("start longer than 1");
  a_start_sets_active: assert property (
    s_wave_launch |-> waveReq.active) else $error("start without active");
  a_zero_never_plays: assert property (
    waveReq.start |-> waveReq.index != 7'h00) else $error("zero index played");
  a_index_held: assert property (
    waveReq.active && !waveReq.start |-> $stable(waveReq.index))
    else $error("index changed during play");
  a_done_ends_play: assert property (
    s_wave_end |=> !waveReq.active ##1 (waveReq.start || !waveReq.active))
    else $error("play not ended by done");
  a_quiet_while_wait: assert property (
    engineIdle |-> !waveReq.active && !waveReq.start)
    else $error("waveform during delay");
  a_delay_length: assert property (
    $fell(engineIdle) && seqBusy |->
      ((int'(idleLen_reg) - 1) % DELAY_UNIT_CYCLES) == 0)
    else $error("delay length wrong");
endmodule
bind wss_sequencer wss_seq_checker #(
  .NUM_SLOTS(NUM_SLOTS),
  .DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)
) u_chk (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .busReq(busReq),
  .busRdata(busRdata),
  .waveReq(waveReq),
  .waveDone(waveDone),
  .seqBusy(seqBusy),
  .engineIdle(engineIdle)
);

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import wss_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  wss_bus_req_t busReq = '0;
  logic [7:0] busRdata;
  wss_wave_req_t waveReq;
  logic waveDone = 1'b0;
  logic seqBusy;
  logic engineIdle;
  logic [2:0] libCnt = 3'h0;
  localparam int UNIT = 4;
  int idleCnt = 0;
  logic [6:0] starts [$];
  logic [7:0] expQ [$];
  int n_fail = 0;
  int checked = 0;
  wss_sequencer #(.NUM_SLOTS(8), .DELAY_UNIT_CYCLES(UNIT)) dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .busReq(busReq),
    .busRdata(busRdata),
    .waveReq(waveReq),
    .waveDone(waveDone),
    .seqBusy(seqBusy),
    .engineIdle(engineIdle)
  );
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // library stand-in: done 4 cycles after start
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (engineIdle === 1'b1) idleCnt <= idleCnt + 1;
    waveDone <= (waveReq.start !== 1'b1) && (libCnt == 3'h1);
    if (waveReq.start === 1'b1) begin
      starts.push_back(waveReq.index);
      libCnt <= 3'h3;
    end else if (libCnt != 3'h0) begin
      libCnt <= libCnt - 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1 check(busRdata, exp);
    @(posedge ref_clk);
  endtask
  task automatic run_seq(input int expIdle);
    int k;
    int s0;
    int i0;
    s0 = starts.size();
    i0 = idleCnt;
    wr(8'h0c, 8'h01);
    for (k = 0; k < 1000; k++) begin
      @(posedge ref_clk);
      #1;
      if (seqBusy === 1'b0) break;
    end
    if (k == 1000) begin
      n_fail++;
      tally_and_finish();
    end
    check(8'(starts.size() - s0), 8'(expQ.size()));
    foreach (expQ[i]) check({1'b0, starts[s0 + i]}, expQ[i]);
    check(8'(idleCnt - i0), 8'(expIdle));
    rd(8'h0c, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(8'h0f, 8'h01);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h10, 8'ha5);
    wr(8'h11, 8'h5a);
    rd(8'h10, 8'ha5);
    rd(8'h11, 8'h5a);
    // waveform, two-unit delay, waveform, stop on zero
    wr(8'h0f, 8'h03);
    wr(8'h10, 8'h82);
    wr(8'h11, 8'h7f);
    wr(8'h12, 8'h00);
    expQ = '{8'h03, 8'h7f};
    run_seq(2 * UNIT + 1);
    // eight waveforms, sequence ends after the last slot
    for (int i = 0; i < 8; i++) wr(8'(8'h0f + i), 8'(i + 1));
    expQ = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    run_seq(0);
    rd(8'h20, 8'h70);
    // zero in the first slot plays nothing
    wr(8'h0f, 8'h00);
    expQ = {};
    run_seq(0);
    rd(8'h20, 8'h00);
    // a delay cut short by clearing go
    wr(8'h0f, 8'h85);
    wr(8'h0c, 8'h01);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h20, 8'h00);
    check(8'(starts.size()), 8'h0a);
    tally_and_finish();
  end
endmodule
